// >>> vfo_tuning_pkg.sv
// How it works
// - register A knob detent steps 5 kHz
// - register B steps 25 kHz, 15 wide variant
// - clockwise raises frequency, counterclockwise lowers it
// - stepping past top edge wraps to bottom
// - stepping below bottom edge wraps to top
// - selector picks registers or memory channels 1-5
// - register A lamp lit while A selected
// - scan button toggles; restart resumes stopped position
// - write stores A to memory or copies
// - priority button toggles; lamp shows priority on
// - priority visits memory channel every five seconds
// - three digits 1MHz-10kHz plus 5 kHz lamp
// - transmit lamp in transmit; receive lamp squelch-open
// - standard duplex: transmit is receive minus offset
// - swapped shift exchanges receive and transmit frequencies
// - plus/minus switch puts transmit above/below receive on the wide variant; standard transmits below, but above with swapped shift
// - bar meter: strength on receive, output transmit
// - tone-call held: transmit with 1750 Hz burst (standard variant only)
// - scan selector: full band or programmed limits
// - stop timer on/off, interval 5-20 seconds
// - auto-stop on busy or on empty channel
// - power-on presets both registers to preset
// - switching registers keeps other register's frequency
// - write copies A into B, or B into A
package vfo_tuning_pkg;

	// ------------------------------------------------------------
	// frequencies, all in kHz
	// ------------------------------------------------------------
	localparam int FREQ_W = 18;
	typedef logic [FREQ_W-1:0] freq_t;

	localparam freq_t BAND_LO_STD  = 18'd144000;
	localparam freq_t BAND_HI_STD  = 18'd145995;
	localparam freq_t BAND_LO_WIDE = 18'd143800;
	localparam freq_t BAND_HI_WIDE = 18'd148195;
	localparam freq_t PRESET_STD   = 18'd145000;
	localparam freq_t PRESET_WIDE  = 18'd146010;
	localparam freq_t STEP_A       = 18'd5;
	localparam freq_t STEP_B_STD   = 18'd25;
	localparam freq_t STEP_B_WIDE  = 18'd15;
	localparam freq_t OFFSET_RESET = 18'd600;

	localparam int MEM_CHANNELS = 5;
	localparam int METER_LAMPS  = 7;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 125_000_000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_PER_S      = 1000;
	localparam int MS_CYC        = CLK_HZ / MS_PER_S;
	localparam int PRIO_PERIOD_S = 5;
	localparam int PRIO_DWELL_MS = 100;
	localparam int STOP_MIN_S    = 5;
	localparam int STOP_MAX_S    = 20;

	// ------------------------------------------------------------
	// carriers and states
	// ------------------------------------------------------------
	typedef struct packed {
		logic knob_cw;
		logic knob_ccw;
		logic scan_btn;
		logic write_btn;
		logic prio_btn;
		logic use_memory;
		logic reg_b_sel;
		logic repeater_shift_on;
		logic swapped_shift;
		logic offset_plus;
		logic tone_call;
		logic ptt;
		logic squelch_open;
		logic scan_program;
		logic stop_timer_on;
		logic stop_on_empty;
	} panel_sw_t;

	typedef struct packed {
		logic [3:0] mhz;
		logic [3:0] k100;
		logic [3:0] k10;
		logic       k5;
	} display_t;

	typedef enum logic [2:0] {
		SCAN_IDLE = 3'b001,
		SCAN_RUN  = 3'b010,
		SCAN_HOLD = 3'b100
	} scan_state_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; a change is taken once stages two
// and three agree, which also rejects single-sample glitches
module pin_sync #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// ------------------------------------------------------------
	// per-bit stages
	// ------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1[b]  <= 1'b0;
					s2[b]  <= 1'b0;
					s3[b]  <= 1'b0;
					o_q[b] <= 1'b0;
				end else begin
					s1[b] <= i_d[b];
					s2[b] <= s1[b];
					s3[b] <= s2[b];
					if (s2[b] == s3[b]) begin
						o_q[b] <= s3[b];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> vfo_tuning_scan_controller.sv
`timescale 1ns/1ps
`default_nettype none
module vfo_tuning_scan_controller #(
	parameter bit WIDE_BAND = 1'b0,
	parameter int MS_CYC    = vfo_tuning_pkg::MS_CYC
) (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_arst_n,
	input  wire vfo_tuning_pkg::panel_sw_t   i_panel,
	input  wire logic [2:0]                  i_mem_chan,
	input  wire vfo_tuning_pkg::freq_t       i_scan_lo,
	input  wire vfo_tuning_pkg::freq_t       i_scan_hi,
	input  wire logic [7:0]                  i_scan_speed_ms,
	input  wire logic [4:0]                  i_stop_time_s,
	input  wire vfo_tuning_pkg::freq_t       i_offset_value,
	input  wire logic                        i_offset_load,
	input  wire logic [2:0]                  i_signal_level,
	input  wire logic [2:0]                  i_rf_level,
	output var  vfo_tuning_pkg::freq_t       o_synth_freq,
	output var  vfo_tuning_pkg::display_t    o_display,
	output logic                             o_reg_a_lamp,
	output logic                             o_priority_lamp,
	output logic                             o_tx_lamp,
	output logic                             o_rx_lamp,
	output logic [6:0]                       o_signal_output_meter,
	output logic                             o_tone_on,
	output logic                             o_scanning
);
	import vfo_tuning_pkg::*;

	// ------------------------------------------------------------
	// reset release and pin synchronisation
	// ------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic       rst_n;
	panel_sw_t  sw;
	logic [15:0] sw_raw;

	// async assert, clocked release
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	pin_sync #(
		.W (16)
	) u_pin_sync (
		.i_clk   (i_sys_clk),
		.i_rst_n (rst_n),
		.i_d     (i_panel),
		.o_q     (sw_raw)
	);
	assign sw = panel_sw_t'(sw_raw);

	// ------------------------------------------------------------
	// variant constants
	// ------------------------------------------------------------
	localparam freq_t BAND_LO = WIDE_BAND ? BAND_LO_WIDE : BAND_LO_STD;
	localparam freq_t BAND_HI = WIDE_BAND ? BAND_HI_WIDE : BAND_HI_STD;
	localparam freq_t PRESET  = WIDE_BAND ? PRESET_WIDE : PRESET_STD;
	localparam freq_t STEP_B  = WIDE_BAND ? STEP_B_WIDE : STEP_B_STD;

	// wrap-around stepper shared by knob and scan
	function automatic freq_t step_freq(input freq_t f, input logic up,
		input freq_t st, input freq_t lo, input freq_t hi);
		freq_t r;
		r = f;
		if (up) begin
			r = (f > hi - st) ? lo : f + st;
		end else begin
			r = (f < lo + st) ? hi : f - st;
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// button edges
	// ------------------------------------------------------------
	logic [4:0] btn_prev;
	logic [4:0] btn_now;
	logic [4:0] btn_rise;
	logic       knob_up;
	logic       knob_dn;
	logic       scan_press;
	logic       write_press;
	logic       prio_press;

	assign btn_now     = {sw.knob_cw, sw.knob_ccw, sw.scan_btn,
	                      sw.write_btn, sw.prio_btn};
	assign btn_rise    = btn_now & ~btn_prev;
	assign knob_up     = btn_rise[4];
	assign knob_dn     = btn_rise[3];
	assign scan_press  = btn_rise[2];
	assign write_press = btn_rise[1];
	assign prio_press  = btn_rise[0];

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			btn_prev <= 5'h00;
		end else begin
			btn_prev <= btn_now;
		end
	end

	// ------------------------------------------------------------
	// time base: millisecond and second ticks
	// ------------------------------------------------------------
	logic [16:0] ms_cnt;
	logic [9:0]  sec_ms;
	logic        ms_tick;
	logic        sec_tick;

	assign ms_tick  = (ms_cnt == 17'(MS_CYC - 1));
	assign sec_tick = ms_tick && (sec_ms == 10'(MS_PER_S - 1));

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 17'h00000;
			sec_ms <= 10'h000;
		end else begin
			ms_cnt <= ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
			if (ms_tick) begin
				sec_ms <= sec_tick ? 10'h000 : sec_ms + 10'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// scan control
	// ------------------------------------------------------------
	scan_state_t state;
	scan_state_t next_state;
	logic [7:0]  scan_ms;
	logic [4:0]  hold_s;
	logic [4:0]  stop_lim;
	logic        step_tick;
	logic        stop_hit;
	logic        hold_done;
	logic        scan_adv;

	// stepping rate from the speed setting, never faster than 1 ms
	assign step_tick = (state == SCAN_RUN) && ms_tick
	                   && (scan_ms >= i_scan_speed_ms);
	// busy or empty stop, chosen by the socket setting
	assign stop_hit  = sw.stop_on_empty ? !sw.squelch_open
	                                    : sw.squelch_open;
	assign stop_lim  = (i_stop_time_s < 5'(STOP_MIN_S)) ? 5'(STOP_MIN_S) :
	                   (i_stop_time_s > 5'(STOP_MAX_S)) ? 5'(STOP_MAX_S) :
	                   i_stop_time_s;
	assign hold_done = sw.stop_timer_on && sec_tick
	                   && (hold_s + 5'h01 >= stop_lim);
	assign scan_adv  = step_tick && !stop_hit;

	// press toggles; position registers are never cleared, so a
	// restart continues where the scan left off
	always_comb begin
		next_state = state;
		unique case (state)
			SCAN_IDLE: if (scan_press) next_state = SCAN_RUN;
			SCAN_RUN: begin
				if (scan_press) begin
					next_state = SCAN_IDLE;
				end else if (step_tick && stop_hit) begin
					next_state = SCAN_HOLD;
				end
			end
			SCAN_HOLD: begin
				if (scan_press || hold_done) begin
					next_state = SCAN_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= SCAN_IDLE;
			scan_ms <= 8'h00;
			hold_s  <= 5'h00;
		end else begin
			state <= next_state;
			if (state != SCAN_RUN || step_tick) begin
				scan_ms <= 8'h00;
			end else if (ms_tick) begin
				scan_ms <= scan_ms + 8'h01;
			end
			if (state != SCAN_HOLD) begin
				hold_s <= 5'h00;
			end else if (sec_tick) begin
				hold_s <= hold_s + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// tuning registers and memory channels
	// ------------------------------------------------------------
	freq_t      reg_a;
	freq_t      reg_b;
	freq_t      chan_mem [MEM_CHANNELS];
	logic [2:0] scan_chan;
	logic [2:0] sel_chan;
	logic [2:0] op_chan;
	freq_t      sel_reg;
	freq_t      step_sel;
	freq_t      scan_lo;
	freq_t      scan_hi;
	freq_t      new_sel;
	logic       tune_ev;
	logic       upd_sel;
	logic       copy_to_a;
	logic       copy_to_b;
	logic       store_mem;
	freq_t      next_reg_a;
	freq_t      next_reg_b;

	// channel switch 1..5 mapped to 0..4; out-of-range reads as 1
	assign sel_chan  = (i_mem_chan >= 3'd1 && i_mem_chan <= 3'd5)
	                   ? i_mem_chan - 3'd1 : 3'd0;
	assign op_chan   = (state != SCAN_IDLE && sw.use_memory)
	                   ? scan_chan : sel_chan;
	assign sel_reg   = sw.reg_b_sel ? reg_b : reg_a;
	assign step_sel  = sw.reg_b_sel ? STEP_B : STEP_A;
	assign scan_lo   = sw.scan_program ? i_scan_lo : BAND_LO;
	assign scan_hi   = sw.scan_program ? i_scan_hi : BAND_HI;
	// knob is ignored while a scan owns the register
	assign tune_ev   = !sw.use_memory && (state == SCAN_IDLE)
	                   && (knob_up || knob_dn);
	assign new_sel   = tune_ev
	                   ? step_freq(sel_reg, knob_up, step_sel,
	                               BAND_LO, BAND_HI)
	                   : step_freq(sel_reg, 1'b1, step_sel,
	                               scan_lo, scan_hi);
	assign upd_sel   = tune_ev || (scan_adv && !sw.use_memory);
	assign copy_to_a = write_press && !sw.use_memory && !sw.reg_b_sel;
	assign copy_to_b = write_press && !sw.use_memory && sw.reg_b_sel;
	assign store_mem = write_press && sw.use_memory;
	assign next_reg_a = copy_to_a ? reg_b :
	                    (upd_sel && !sw.reg_b_sel) ? new_sel : reg_a;
	assign next_reg_b = copy_to_b ? reg_a :
	                    (upd_sel && sw.reg_b_sel) ? new_sel : reg_b;

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_a     <= PRESET;
			reg_b     <= PRESET;
			scan_chan <= 3'd0;
			for (int i = 0; i < MEM_CHANNELS; i++) begin
				chan_mem[i] <= PRESET;
			end
		end else begin
			reg_a <= next_reg_a;
			reg_b <= next_reg_b;
			if (store_mem) begin
				chan_mem[sel_chan] <= reg_a;
			end
			if (scan_adv && sw.use_memory) begin
				scan_chan <= (scan_chan == 3'(MEM_CHANNELS - 1))
				             ? 3'd0 : scan_chan + 3'd1;
			end
		end
	end

	// ------------------------------------------------------------
	// priority watch
	// ------------------------------------------------------------
	logic       prio_on;
	logic       prio_active;
	logic [2:0] prio_s;
	logic [6:0] dwell_ms;
	logic       prio_due;

	assign prio_due = prio_on && sec_tick
	                  && (prio_s == 3'(PRIO_PERIOD_S - 1));

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_on     <= 1'b0;
			prio_active <= 1'b0;
			prio_s      <= 3'd0;
			dwell_ms    <= 7'd0;
		end else begin
			if (prio_press) begin
				prio_on <= !prio_on;
			end
			if (!prio_on || prio_due) begin
				prio_s <= 3'd0;
			end else if (sec_tick) begin
				prio_s <= prio_s + 3'd1;
			end
			// brief visit, then back to the working frequency
			if (!prio_on) begin
				prio_active <= 1'b0;
			end else if (prio_due) begin
				prio_active <= 1'b1;
				dwell_ms    <= 7'd0;
			end else if (prio_active && ms_tick) begin
				dwell_ms <= dwell_ms + 7'd1;
				if (dwell_ms == 7'(PRIO_DWELL_MS - 1)) begin
					prio_active <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// receive/transmit frequency and duplex shift
	// ------------------------------------------------------------
	freq_t    offset;
	freq_t    base;
	freq_t    shifted;
	freq_t    rx_f;
	freq_t    tx_f;
	freq_t    carrier;
	logic     tx_mode;
	logic     tone_req;
	logic     single_frequency;
	logic     prio_visit;
	display_t disp;

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			offset <= OFFSET_RESET;
		end else if (i_offset_load) begin
			offset <= i_offset_value;
		end
	end

	// tone burst exists only on the standard variant
	assign tone_req   = sw.tone_call && !WIDE_BAND;
	assign tx_mode    = sw.ptt || tone_req;
	assign single_frequency = !sw.repeater_shift_on;
	// priority visits only on receive with the registers
	assign prio_visit = prio_active && !tx_mode && !sw.use_memory;
	assign base       = (prio_visit || sw.use_memory)
	                    ? chan_mem[prio_visit ? sel_chan : op_chan]
	                    : sel_reg;
	assign shifted    = (WIDE_BAND && sw.offset_plus)
	                    ? base + offset
	                    : base - offset;
	assign rx_f       = (!single_frequency && sw.swapped_shift)
	                    ? shifted : base;
	assign tx_f       = single_frequency ? base :
	                    sw.swapped_shift ? base : shifted;
	assign carrier    = tx_mode ? tx_f : rx_f;

	// decimal places of the carrier, 5 kHz place on its own lamp
	assign disp.mhz  = 4'((carrier / 18'd1000) % 18'd10);
	assign disp.k100 = 4'((carrier / 18'd100) % 18'd10);
	assign disp.k10  = 4'((carrier / 18'd10) % 18'd10);
	assign disp.k5   = ((carrier % 18'd10) >= 18'd5);

	// ------------------------------------------------------------
	// bar meter
	// ------------------------------------------------------------
	logic [2:0] meter_lvl;
	logic [6:0] bar;

	assign meter_lvl = tx_mode ? i_rf_level : i_signal_level;

	genvar m;
	generate
		for (m = 0; m < METER_LAMPS; m++) begin : g_bar
			assign bar[m] = (meter_lvl > 3'(m));
		end
	endgenerate

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_synth_freq          <= PRESET;
			o_display             <= '0;
			o_reg_a_lamp          <= 1'b0;
			o_priority_lamp       <= 1'b0;
			o_tx_lamp             <= 1'b0;
			o_rx_lamp             <= 1'b0;
			o_signal_output_meter <= 7'h00;
			o_tone_on             <= 1'b0;
			o_scanning            <= 1'b0;
		end else begin
			o_synth_freq          <= carrier;
			o_display             <= disp;
			o_reg_a_lamp          <= !sw.use_memory && !sw.reg_b_sel;
			o_priority_lamp       <= prio_on;
			o_tx_lamp             <= tx_mode;
			o_rx_lamp             <= !tx_mode && sw.squelch_open;
			o_signal_output_meter <= bar;
			o_tone_on             <= tone_req;
			o_scanning            <= (state == SCAN_RUN);
		end
	end
endmodule
`default_nettype wire

// >>> vfo_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks, standard band variant only
module vfo_props (
	input wire logic                      i_sys_clk,
	input wire logic                      i_arst_n,
	input wire vfo_tuning_pkg::panel_sw_t i_panel,
	input wire logic [2:0]                i_signal_level,
	input wire logic [2:0]                i_rf_level,
	input wire vfo_tuning_pkg::freq_t     o_synth_freq,
	input wire vfo_tuning_pkg::display_t  o_display,
	input wire logic                      o_reg_a_lamp,
	input wire logic                      o_priority_lamp,
	input wire logic                      o_tx_lamp,
	input wire logic                      o_rx_lamp,
	input wire logic [6:0]                o_signal_output_meter,
	input wire logic                      o_tone_on
);
	import vfo_tuning_pkg::*;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// ------------------------------------------------------------
	// lamps; windows allow for the pin synchroniser
	// ------------------------------------------------------------
	a_reg_a_lamp: assert property (
		(!i_panel.use_memory && $stable(i_panel.reg_b_sel))[*8] |->
		##2 o_reg_a_lamp == !$past(i_panel.reg_b_sel, 2))
		else $error("register A lamp wrong");
	a_tx_on_ptt: assert property (
		$rose(i_panel.ptt) |-> ##[3:10] o_tx_lamp)
		else $error("transmit lamp late");
	a_rx_tx_excl: assert property (
		!(o_rx_lamp && o_tx_lamp))
		else $error("receive lamp lit in transmit");
	a_tone_burst: assert property (
		$rose(i_panel.tone_call) |-> ##[3:10] (o_tone_on && o_tx_lamp))
		else $error("tone call did not key");
	a_prio_toggle: assert property (
		$rose(i_panel.prio_btn) && !o_priority_lamp |->
		##[3:10] o_priority_lamp)
		else $error("priority lamp did not toggle");
	// ------------------------------------------------------------
	// frequency and display
	// ------------------------------------------------------------
	a_rx_in_band: assert property (
		(!i_panel.repeater_shift_on)[*8] |->
		o_synth_freq inside {[BAND_LO_STD:BAND_HI_STD]})
		else $error("frequency left the band");
	a_display_bcd: assert property (
		o_display != '0 |->
		o_display.mhz == 4'((o_synth_freq / 1000) % 10) &&
		o_display.k100 == 4'((o_synth_freq / 100) % 10) &&
		o_display.k10 == 4'((o_synth_freq / 10) % 10) &&
		o_display.k5 == ((o_synth_freq % 10) >= 5))
		else $error("display does not match carrier");
	// meter follows the level of the active direction
	a_meter_rx: assert property (
		(!i_panel.ptt && !i_panel.tone_call &&
		$stable(i_signal_level))[*8] |->
		o_signal_output_meter == 7'((8'h01 << i_signal_level) - 8'h01))
		else $error("meter wrong in receive");
	a_meter_tx: assert property (
		(i_panel.ptt && $stable(i_rf_level))[*8] |->
		o_signal_output_meter == 7'((8'h01 << i_rf_level) - 8'h01))
		else $error("meter wrong in transmit");
endmodule
bind vfo_tuning_scan_controller vfo_props i_props (
	.i_sys_clk(i_sys_clk),
	.i_arst_n(i_arst_n),
	.i_panel(i_panel),
	.i_signal_level(i_signal_level),
	.i_rf_level(i_rf_level),
	.o_synth_freq(o_synth_freq),
	.o_display(o_display),
	.o_reg_a_lamp(o_reg_a_lamp),
	.o_priority_lamp(o_priority_lamp),
	.o_tx_lamp(o_tx_lamp),
	.o_rx_lamp(o_rx_lamp),
	.o_signal_output_meter(o_signal_output_meter),
	.o_tone_on(o_tone_on)
);
`default_nettype wire

// >>> panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// operator at the panel and the synthesiser word latch
module panel_model (
	input  wire logic                      i_clk,
	input  wire vfo_tuning_pkg::freq_t     i_synth_freq,
	output var  vfo_tuning_pkg::panel_sw_t o_panel
);
	import vfo_tuning_pkg::*;
	freq_t tuned;
	initial o_panel = '0;
	// synthesiser takes the word one clock late
	always_ff @(posedge i_clk) tuned <= i_synth_freq;
	// level change, then time for synchroniser and output stage
	task automatic set_sw(input panel_sw_t m, input bit v);
		@(posedge i_clk);
		o_panel <= v ? (o_panel | m) : (o_panel & ~m);
		repeat (10) @(posedge i_clk);
	endtask
	// long low phase so two presses never merge into one
	task automatic tap(input panel_sw_t m);
		set_sw(m, 1'b1);
		set_sw(m, 1'b0);
	endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vfo_tuning_pkg::*;
	// ------------------------------------------------------------
	// panel masks, struct order from the top bit
	// ------------------------------------------------------------
	localparam panel_sw_t CW = 16'h8000, CCW = 16'h4000;
	localparam panel_sw_t SCAN = 16'h2000, WR = 16'h1000;
	localparam panel_sw_t PRIO = 16'h0800, MEM = 16'h0400;
	localparam panel_sw_t REGB = 16'h0200, REPEATER_SHIFT_ON = 16'h0100;
	localparam panel_sw_t SWAP = 16'h0080, TONE = 16'h0020;
	localparam panel_sw_t PTT = 16'h0010, SQL = 16'h0008;
	localparam panel_sw_t PGM = 16'h0004, TMR = 16'h0002;
	localparam panel_sw_t EMPTY = 16'h0001;
	logic       i_sys_clk = 1'b0;
	logic       i_arst_n = 1'b0;
	logic [2:0] mem_chan = 3'h2;
	logic [2:0] sig_lvl = 3'h0;
	logic [2:0] rf_lvl = 3'h0;
	logic       off_ld = 1'b0;
	panel_sw_t  panel;
	freq_t      synth_o, synth, h, a;
	display_t   disp;
	logic       lamp_a, lamp_p, tx, rx, tone, scanning;
	logic [6:0] meter;
	int         err_count = 0, num_checks = 0, cyc = 0;
	assign synth = i_pm.tuned;
	initial forever #4 i_sys_clk = ~i_sys_clk;
	panel_model i_pm (.i_clk(i_sys_clk), .i_synth_freq(synth_o),
		.o_panel(panel));
	// short ms tick keeps the five second priority period affordable
	vfo_tuning_scan_controller #(.WIDE_BAND(1'b0), .MS_CYC(5)) i_dut (
		.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_panel(panel),
		.i_mem_chan(mem_chan), .i_scan_lo(18'd144100),
		.i_scan_hi(18'd144110), .i_scan_speed_ms(8'h09),
		.i_stop_time_s(5'h05), .i_offset_value(18'd1000),
		.i_offset_load(off_ld), .i_signal_level(sig_lvl),
		.i_rf_level(rf_lvl), .o_synth_freq(synth_o), .o_display(disp),
		.o_reg_a_lamp(lamp_a), .o_priority_lamp(lamp_p),
		.o_tx_lamp(tx), .o_rx_lamp(rx), .o_signal_output_meter(meter),
		.o_tone_on(tone), .o_scanning(scanning));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	task automatic chk(input string nm, input logic [17:0] e,
		input logic [17:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait for a given synthesiser word
	task automatic wait_freq(input freq_t v, input int lim);
		int n;
		n = 0;
		while (synth !== v && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard, about 75 percent over the longest path
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		tick(6);
		i_arst_n <= 1'b1;
		tick(12);
		chk("freq", 18'd145000, synth);
		chk("lamp_a", 1'b1, lamp_a);
		chk("disp", 18'h00A00, disp);
		i_pm.tap(CW);
		chk("freq", 18'd145005, synth);
		i_pm.tap(CCW);
		chk("freq", 18'd145000, synth);
		i_pm.set_sw(REGB, 1'b1);
		chk("freq", 18'd145000, synth);
		chk("lamp_a", 1'b0, lamp_a);
		i_pm.tap(CW);
		chk("freq", 18'd145025, synth);
		i_pm.set_sw(REGB, 1'b0);
		chk("freq", 18'd145000, synth);
		i_pm.tap(WR);
		chk("freq", 18'd145025, synth);
		// walk B down to the bottom edge, then across both edges
		i_pm.set_sw(REGB, 1'b1);
		repeat (41) i_pm.tap(CCW);
		chk("freq", 18'd144000, synth);
		i_pm.tap(CCW);
		chk("freq", 18'd145995, synth);
		i_pm.tap(CW);
		chk("freq", 18'd144000, synth);
		i_pm.set_sw(REGB, 1'b0);
		i_pm.set_sw(REPEATER_SHIFT_ON, 1'b1);
		i_pm.set_sw(PTT, 1'b1);
		chk("freq", 18'd144425, synth);
		chk("tx", 1'b1, tx);
		i_pm.set_sw(SWAP, 1'b1);
		chk("freq", 18'd145025, synth);
		i_pm.set_sw(PTT, 1'b0);
		chk("freq", 18'd144425, synth);
		// one-cycle load of a new offset
		off_ld <= 1'b1;
		tick(1);
		off_ld <= 1'b0;
		tick(3);
		chk("offset", 18'd144025, synth);
		i_pm.set_sw(SWAP, 1'b0);
		i_pm.set_sw(REPEATER_SHIFT_ON, 1'b0);
		sig_lvl <= 3'h3;
		rf_lvl <= 3'h5;
		i_pm.set_sw(SQL, 1'b1);
		chk("rx", 1'b1, rx);
		chk("meter", 7'h07, meter);
		i_pm.set_sw(PTT, 1'b1);
		chk("rx", 1'b0, rx);
		chk("meter", 7'h1F, meter);
		i_pm.set_sw(PTT, 1'b0);
		i_pm.set_sw(SQL, 1'b0);
		i_pm.set_sw(TONE, 1'b1);
		chk("tone", 1'b1, tone);
		i_pm.set_sw(TONE, 1'b0);
		chk("tone", 1'b0, tone);
		// scan: busy stop, then resume from the stopped place
		i_pm.tap(SCAN);
		chk("scanning", 1'b1, scanning);
		tick(300);
		chk("scan_step", 1'b1, synth != 18'd145025 &&
			(synth - 18'd145025) % 5 == 0);
		i_pm.set_sw(SQL, 1'b1);
		tick(150);
		h = synth;
		tick(250);
		chk("busy_stop", h, synth);
		i_pm.set_sw(SQL, 1'b0);
		i_pm.tap(SCAN);
		wait_freq(h + 18'd5, 250);
		chk("resume", h + 18'd5, synth);
		i_pm.tap(SCAN);
		chk("scanning", 1'b0, scanning);
		i_pm.set_sw(EMPTY, 1'b1);
		i_pm.tap(SCAN);
		tick(150);
		h = synth;
		tick(250);
		chk("empty_stop", h, synth);
		// stop timer restarts the held scan; open squelch lets it step
		i_pm.set_sw(TMR | SQL, 1'b1);
		wait_freq(h + 18'd5, 26000);
		chk("timed_resume", h + 18'd5, synth);
		i_pm.set_sw(TMR | SQL | EMPTY, 1'b0);
		i_pm.tap(SCAN);
		chk("scanning", 1'b0, scanning);
		// memory store and priority visits
		a = synth;
		i_pm.set_sw(MEM, 1'b1);
		chk("freq", 18'd145000, synth);
		i_pm.tap(WR);
		chk("freq", a, synth);
		mem_chan <= 3'h3;
		tick(10);
		chk("freq", 18'd145000, synth);
		mem_chan <= 3'h2;
		i_pm.set_sw(MEM, 1'b0);
		i_pm.tap(CW);
		chk("freq", a + 18'd5, synth);
		i_pm.tap(PRIO);
		chk("lamp_p", 1'b1, lamp_p);
		wait_freq(a, 60000);
		chk("prio_visit", a, synth);
		wait_freq(a + 18'd5, 12000);
		chk("prio_back", a + 18'd5, synth);
		i_pm.tap(PRIO);
		chk("lamp_p", 1'b0, lamp_p);
		// memory scan starts at channel 1, then steps to channel 2
		i_pm.set_sw(MEM, 1'b1);
		i_pm.tap(SCAN);
		chk("mem_scan", 18'd145000, synth);
		wait_freq(a, 200);
		chk("mem_scan", a, synth);
		i_pm.tap(SCAN);
		i_pm.set_sw(MEM, 1'b0);
		// programmed limits: jump to the low limit, wrap at the high one
		i_pm.set_sw(PGM, 1'b1);
		i_pm.tap(SCAN);
		wait_freq(18'd144110, 300);
		chk("prog_top", 18'd144110, synth);
		wait_freq(18'd144100, 100);
		chk("prog_wrap", 18'd144100, synth);
		stop_test();
	end
endmodule
`default_nettype wire
